// file: rsg_pkg.sv
// Package of raster timing constants and pixel types for the sync generator
package rsg_pkg;

  // Pixel clock rate the timing is written for, in MHz
  localparam int PIXEL_CLK_MHZ = 25;

  // Horizontal timing in pixel-clock cycles
  localparam int H_SYNC   = 96;
  localparam int H_BACK   = 48;
  localparam int H_ACTIVE = 640;
  localparam int H_FRONT  = 16;
  localparam int H_TOTAL  = H_SYNC + H_BACK + H_ACTIVE + H_FRONT;

  // Vertical timing in lines
  localparam int V_SYNC   = 2;
  localparam int V_BACK   = 33;
  localparam int V_ACTIVE = 480;
  localparam int V_FRONT  = 10;
  localparam int V_TOTAL  = V_SYNC + V_BACK + V_ACTIVE + V_FRONT;

  // Counter widths
  localparam int H_W = 10;
  localparam int V_W = 10;

  // Colour depth per channel
  localparam int COLOR_W = 4;
  localparam int PIXEL_W = 3 * COLOR_W;

  // Reset values
  localparam logic [H_W-1:0]     H_RESET     = 10'h000;
  localparam logic [V_W-1:0]     V_RESET     = 10'h000;
  localparam logic [PIXEL_W-1:0] PIXEL_BLANK = 12'h000;

  // Pixel word: red in the top nibble, blue in the bottom
  typedef logic [PIXEL_W-1:0] rsg_pixel_t;

endpackage

// file: rsg_stream_if.sv
// Valid/ready pixel stream between the source buffer and the raster core
`timescale 1ns/1ps
interface rsg_stream_if;
  logic                valid;
  logic                ready;
  rsg_pkg::rsg_pixel_t data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// file: rsg_skid_buf.sv
// Two-entry pixel buffer with valid and ready on both sides
`timescale 1ns/1ps
module rsg_skid_buf
#(
  parameter int WIDTH = rsg_pkg::PIXEL_W,
  parameter int DEPTH = 2
)
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Draining side
  rsg_stream_if.src             out
);

  initial
  begin
    if (DEPTH != 2)
      $error("rsg_skid_buf supports DEPTH of 2 only");
  end

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [WIDTH-1:0] mem_next [DEPTH];
  logic             wr_ptr_reg;
  logic             wr_ptr_next;
  logic             rd_ptr_reg;
  logic             rd_ptr_next;
  logic [1:0]       count_reg;
  logic [1:0]       count_next;
  logic             push;
  logic             pop;

  // Handshakes: honest full and empty
  assign in_ready  = (count_reg != 2'h2);
  assign out.valid = (count_reg != 2'h0);
  assign out.data  = mem_reg[rd_ptr_reg]; // Read data from a register
  assign push      = in_valid && in_ready;
  assign pop       = out.valid && out.ready;

  // Next pointer, count and storage
  always_comb
  begin
    mem_next    = mem_reg;
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    if (push)
    begin
      mem_next[wr_ptr_reg] = in_data;
      wr_ptr_next          = ~wr_ptr_reg;
    end
    if (pop)
      rd_ptr_next = ~rd_ptr_reg;
    count_next = count_reg + {1'b0, push} - {1'b0, pop};
  end

  // Register buffer state
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg  <= 2'h0;
      for (int i = 0; i < DEPTH; i++)
        mem_reg[i] <= '0;
    end
    else
    begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg  <= count_next;
      mem_reg    <= mem_next;
    end
  end

endmodule

// file: rsg_raster_sync.sv
// Raster sync generator: 640x480 line and frame sync with 4-bit colour
// Operation
// - Line sync low 96 cycles, then high
// - Line sync starts each row: sync, back, display, front
// - Back porch 48 cycles, colour held zero
// - Display 640 cycles, colour zero in the first, then one new pixel each
// - Front porch 16 cycles, colour zero after the first, which still shows the last pixel
// - Frame sync low for 2 lines
// - Blank 33, show 480, blank 10 lines
// - All timing steps on the pixel clock
// - Red, green, blue each 4-bit levels
// - Sync outputs driven as plain digital pins
`timescale 1ns/1ps
module rsg_raster_sync
#(
  parameter int H_SYNC   = rsg_pkg::H_SYNC,
  parameter int H_BACK   = rsg_pkg::H_BACK,
  parameter int H_ACTIVE = rsg_pkg::H_ACTIVE,
  parameter int H_FRONT  = rsg_pkg::H_FRONT,
  parameter int V_SYNC   = rsg_pkg::V_SYNC,
  parameter int V_BACK   = rsg_pkg::V_BACK,
  parameter int V_ACTIVE = rsg_pkg::V_ACTIVE,
  parameter int V_FRONT  = rsg_pkg::V_FRONT
)
(
  // Pixel clock and synchronous reset
  input  wire logic                        CORE_CLK,
  input  wire logic                        SYS_RST,
  // Pixel source stream
  input  wire logic                        PIX_VALID,
  output logic                             PIX_READY,
  input  wire logic [rsg_pkg::PIXEL_W-1:0] PIX_DATA,
  // Position of the next pixel requested
  output logic [rsg_pkg::H_W-1:0]          PIX_COL,
  output logic [rsg_pkg::V_W-1:0]          PIX_ROW,
  output logic                             PIX_UNDERRUN,
  // Monitor pins
  output logic                             LINE_SYNC_OUT,
  output logic                             FRAME_SYNC_OUT,
  output logic [rsg_pkg::COLOR_W-1:0]      RED_OUT,
  output logic [rsg_pkg::COLOR_W-1:0]      GREEN_OUT,
  output logic [rsg_pkg::COLOR_W-1:0]      BLUE_OUT
);

  localparam int H_TOT = H_SYNC + H_BACK + H_ACTIVE + H_FRONT;
  localparam int V_TOT = V_SYNC + V_BACK + V_ACTIVE + V_FRONT;
  localparam int HW    = rsg_pkg::H_W;
  localparam int VW    = rsg_pkg::V_W;
  localparam int CW    = rsg_pkg::COLOR_W;

  // Counters must fit the programmed totals
  initial
  begin
    if (H_TOT > (1 << HW) || V_TOT > (1 << VW) || H_SYNC < 1 || V_SYNC < 1
        || H_ACTIVE < 1 || V_ACTIVE < 1)
      $error("rsg_raster_sync: timing does not fit the counters");
  end

  typedef enum logic [1:0] {ST_SYNC, ST_BACK, ST_SHOW, ST_FRONT} rsg_phase_t;

  // Phase of a position within a line or a frame
  function automatic rsg_phase_t phase_of(input int pos, input int sync,
                                          input int back, input int show);
    if (pos < sync)
      return ST_SYNC;
    else if (pos < sync + back)
      return ST_BACK;
    else if (pos < sync + back + show)
      return ST_SHOW;
    else
      return ST_FRONT;
  endfunction

  // Counter restart values, declared before the logic that uses them
  localparam logic [HW-1:0] H_RESET_C = rsg_pkg::H_RESET;
  localparam logic [VW-1:0] V_RESET_C = rsg_pkg::V_RESET;

  rsg_stream_if pix_if ();

  logic [HW-1:0] h_reg;
  logic [HW-1:0] h_next;
  logic [VW-1:0] v_reg;
  logic [VW-1:0] v_next;
  logic          lsync_reg;
  logic          lsync_next;
  logic          fsync_reg;
  logic          fsync_next;
  logic [rsg_pkg::PIXEL_W-1:0] color_reg;
  logic [rsg_pkg::PIXEL_W-1:0] color_next;
  logic          under_reg;
  logic          under_next;
  rsg_phase_t    h_phase;
  rsg_phase_t    v_phase;
  logic          show;

  // Two-entry buffer in the pixel path
  rsg_skid_buf #(
    .WIDTH (rsg_pkg::PIXEL_W),
    .DEPTH (2)
  ) u_buf (
    .clk      (CORE_CLK),
    .rst      (SYS_RST),
    .in_valid (PIX_VALID),
    .in_ready (PIX_READY),
    .in_data  (PIX_DATA),
    .out      (pix_if.src)
  );

  // Current position decode
  assign h_phase = phase_of(int'(h_reg), H_SYNC, H_BACK, H_ACTIVE);
  assign v_phase = phase_of(int'(v_reg), V_SYNC, V_BACK, V_ACTIVE);
  assign show    = (h_phase == ST_SHOW) && (v_phase == ST_SHOW);
  assign pix_if.ready = show;

  // Next counters, sync levels and colour
  always_comb
  begin
    h_next = h_reg + 10'h001;
    v_next = v_reg;
    if (int'(h_reg) == H_TOT - 1)
    begin
      h_next = H_RESET_C;
      if (int'(v_reg) == V_TOT - 1)
        v_next = V_RESET_C;
      else
        v_next = v_reg + 10'h001;
    end
    lsync_next = (phase_of(int'(h_next), H_SYNC, H_BACK, H_ACTIVE)
                  != ST_SYNC);
    fsync_next = (phase_of(int'(v_next), V_SYNC, V_BACK, V_ACTIVE)
                  != ST_SYNC);
    color_next = rsg_pkg::PIXEL_BLANK;
    under_next = 1'b0;
    if (show)
    begin
      if (pix_if.valid)
        color_next = pix_if.data;
      else
        under_next = 1'b1; // Source starved: black pixel
    end
  end

  // Register raster state
  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
    begin
      h_reg     <= H_RESET_C;
      v_reg     <= V_RESET_C;
      lsync_reg <= 1'b1;
      fsync_reg <= 1'b1;
      color_reg <= rsg_pkg::PIXEL_BLANK;
      under_reg <= 1'b0;
    end
    else
    begin
      h_reg     <= h_next;
      v_reg     <= v_next;
      lsync_reg <= lsync_next;
      fsync_reg <= fsync_next;
      color_reg <= color_next;
      under_reg <= under_next;
    end
  end

  // Pin outputs straight from flip-flops
  assign LINE_SYNC_OUT  = lsync_reg;
  assign FRAME_SYNC_OUT = fsync_reg;
  assign RED_OUT        = color_reg[3*CW-1:2*CW];
  assign GREEN_OUT      = color_reg[2*CW-1:CW];
  assign BLUE_OUT       = color_reg[CW-1:0];
  assign PIX_UNDERRUN   = under_reg;

  // Pixel position, valid during display only
  assign PIX_COL = show ? h_reg - HW'(H_SYNC + H_BACK) : '0;
  assign PIX_ROW = show ? v_reg - VW'(V_SYNC + V_BACK) : '0;

endmodule

// file: rsg_check_monitor.sv
// Checker of sync pulse lengths and colour gating at the raster pins
`timescale 1ns/1ps
module rsg_check_monitor
#(
  parameter int H_SYNC   = 96,
  parameter int H_BACK   = 48,
  parameter int H_ACTIVE = 640,
  parameter int H_FRONT  = 16,
  parameter int V_SYNC   = 2,
  parameter int V_BACK   = 33,
  parameter int V_ACTIVE = 480,
  parameter int V_FRONT  = 10
)
(
  // Clock and reset
  input wire logic       CORE_CLK,
  input wire logic       SYS_RST,
  // Observed outputs
  input wire logic       PIX_READY,
  input wire logic       PIX_UNDERRUN,
  input wire logic       LINE_SYNC_OUT,
  input wire logic       FRAME_SYNC_OUT,
  input wire logic [3:0] RED_OUT,
  input wire logic [3:0] GREEN_OUT,
  input wire logic [3:0] BLUE_OUT
);
  localparam int HT = H_SYNC + H_BACK + H_ACTIVE + H_FRONT;
  localparam int VT = V_SYNC + V_BACK + V_ACTIVE + V_FRONT;
  int   lo_reg;
  int   hi_reg;
  int   flo_reg;
  int   fhi_reg;
  logic seen_reg;
  logic fseen_reg;
  logic lit;
  // Run lengths of each sync level; first pulses after reset are short
  always_ff @(posedge CORE_CLK)
    if (SYS_RST)
    begin
      lo_reg    <= 0;
      hi_reg    <= 0;
      flo_reg   <= 0;
      fhi_reg   <= 0;
      seen_reg  <= 1'b0;
      fseen_reg <= 1'b0;
    end
    else
    begin
      lo_reg    <= LINE_SYNC_OUT ? 0 : lo_reg + 1;
      hi_reg    <= LINE_SYNC_OUT ? hi_reg + 1 : 0;
      flo_reg   <= FRAME_SYNC_OUT ? 0 : flo_reg + 1;
      fhi_reg   <= FRAME_SYNC_OUT ? fhi_reg + 1 : 0;
      seen_reg  <= seen_reg | (LINE_SYNC_OUT && lo_reg != 0);
      fseen_reg <= fseen_reg | (FRAME_SYNC_OUT && flo_reg != 0);
    end
  assign lit = |{RED_OUT, GREEN_OUT, BLUE_OUT};
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);
  reset_idle_a: assert property ($fell(SYS_RST) |-> LINE_SYNC_OUT &&
    FRAME_SYNC_OUT && PIX_READY && !PIX_UNDERRUN && !lit)
    else $error("outputs not idle after reset");
  line_low_a: assert property (LINE_SYNC_OUT && lo_reg != 0 && seen_reg
    |-> lo_reg == H_SYNC) else $error("line sync low length wrong");
  line_period_a: assert property (!LINE_SYNC_OUT && hi_reg != 0 &&
    seen_reg |-> hi_reg == HT - H_SYNC) else $error("line length wrong");
  frame_low_a: assert property (FRAME_SYNC_OUT && flo_reg != 0 &&
    fseen_reg |-> flo_reg == V_SYNC * HT) else $error("frame sync length");
  frame_period_a: assert property (!FRAME_SYNC_OUT && fhi_reg != 0 &&
    fseen_reg |-> fhi_reg == (VT - V_SYNC) * HT) else $error("frame length");
  colour_cols_a: assert property (lit |-> LINE_SYNC_OUT &&
    hi_reg > H_BACK && hi_reg <= H_BACK + H_ACTIVE)
    else $error("colour outside display columns");
  colour_rows_a: assert property (lit |-> fhi_reg > V_BACK * HT &&
    fhi_reg < (V_BACK + V_ACTIVE + 1) * HT) else $error("colour on blank line");
  frame_align_a: assert property ($changed(FRAME_SYNC_OUT) |->
    $fell(LINE_SYNC_OUT)) else $error("frame sync off line boundary");
endmodule

bind rsg_raster_sync rsg_check_monitor #(.H_SYNC(H_SYNC), .H_BACK(H_BACK),
  .H_ACTIVE(H_ACTIVE), .H_FRONT(H_FRONT), .V_SYNC(V_SYNC), .V_BACK(V_BACK),
  .V_ACTIVE(V_ACTIVE), .V_FRONT(V_FRONT)) chk_u (.CORE_CLK(CORE_CLK),
  .SYS_RST(SYS_RST), .PIX_READY(PIX_READY), .PIX_UNDERRUN(PIX_UNDERRUN),
  .LINE_SYNC_OUT(LINE_SYNC_OUT), .FRAME_SYNC_OUT(FRAME_SYNC_OUT),
  .RED_OUT(RED_OUT), .GREEN_OUT(GREEN_OUT), .BLUE_OUT(BLUE_OUT));

// file: rsg_screen_model.sv
// Monitor model that records lit pixels and counts sync pulses
`timescale 1ns/1ps
module rsg_screen_model
(
  // Pixel clock and pins
  input  wire logic       clk,
  input  wire logic       line_sync,
  input  wire logic       frame_sync,
  input  wire logic [3:0] red,
  input  wire logic [3:0] green,
  input  wire logic [3:0] blue,
  // Sync pulse counts
  output int              line_cnt,
  output int              frame_cnt
);
  rsg_pkg::rsg_pixel_t shown[$];
  logic                line_q = 1'b1;
  logic                frame_q = 1'b1;
  initial
  begin
    line_cnt = 0;
    frame_cnt = 0;
  end
  // Sample the pins on each pixel clock
  always @(posedge clk)
  begin
    if ({red, green, blue} != 12'h000)
      shown.push_back({red, green, blue});
    if (line_q && !line_sync)
      line_cnt++;
    if (frame_q && !frame_sync)
      frame_cnt++;
    line_q = line_sync;
    frame_q = frame_sync;
  end
endmodule

// file: test_raster_sync_generator.sv
// Self-checking bench for the raster sync generator
`timescale 1ns/1ps
module test_raster_sync_generator;
  localparam int HS = 4;
  localparam int HB = 2;
  localparam int HA = 8;
  localparam int HF = 2;
  localparam int VS = 1;
  localparam int VB = 1;
  localparam int VA = 4;
  localparam int VF = 1;
  localparam int HT = HS + HB + HA + HF;
  localparam int VT = VS + VB + VA + VF;
  logic [9:0]          pix_col;
  logic [9:0]          pix_row;
  logic                core_clk = 1'b0;
  logic                sys_rst = 1'b1;
  logic                pix_valid = 1'b0;
  rsg_pkg::rsg_pixel_t pix_data = 12'h000;
  logic                pix_ready;
  logic                pix_underrun;
  logic                line_sync;
  logic                frame_sync;
  logic [3:0]          red;
  logic [3:0]          green;
  logic [3:0]          blue;
  logic                refused = 1'b0;
  int                  line_cnt;
  int                  frame_cnt;
  int                  miscompares = 0;
  int                  cmp_count = 0;
  int                  cycles = 0;
  // Shrunk raster so a frame is short
  rsg_raster_sync #(.H_SYNC(HS), .H_BACK(HB), .H_ACTIVE(HA), .H_FRONT(HF),
    .V_SYNC(VS), .V_BACK(VB), .V_ACTIVE(VA), .V_FRONT(VF)) dut_u (
    .CORE_CLK(core_clk), .SYS_RST(sys_rst), .PIX_VALID(pix_valid),
    .PIX_READY(pix_ready), .PIX_DATA(pix_data), .PIX_COL(pix_col),
    .PIX_ROW(pix_row),
    .PIX_UNDERRUN(pix_underrun), .LINE_SYNC_OUT(line_sync),
    .FRAME_SYNC_OUT(frame_sync), .RED_OUT(red), .GREEN_OUT(green),
    .BLUE_OUT(blue));
  rsg_screen_model mon_u (.clk(core_clk), .line_sync(line_sync),
    .frame_sync(frame_sync), .red(red), .green(green), .blue(blue),
    .line_cnt(line_cnt), .frame_cnt(frame_cnt));
  initial
  begin
    forever #25 core_clk = ~core_clk;
  end
  task automatic end_of_test;
    if (miscompares == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic cmp_pix(input logic [11:0] got, input logic [11:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp_cnt(input int got, input int exp);
    cmp_pix(got[11:0], exp[11:0]);
  endtask
  // Offer one pixel and hold it until taken
  task automatic push(input rsg_pkg::rsg_pixel_t d);
    int n;
    pix_valid = 1'b1;
    pix_data = d;
    for (n = 0; n < 900 && pix_ready !== 1'b1; n++)
    begin
      refused = 1'b1;
      @(posedge core_clk);
      #1;
    end
    @(posedge core_clk);
    #1;
  endtask
  task automatic test_reset_idle;
    cmp_pix({red, green, blue}, 12'h000);
    cmp_pix({8'h00, line_sync, frame_sync, pix_ready, pix_underrun},
      12'h00E);
  endtask
  // One whole frame of pixels, sent back to back
  task automatic test_frame_stream;
    int i;
    for (i = 0; i < HA * VA; i++)
      push(12'hA50 + 12'(i));
    pix_valid = 1'b0;
    for (i = 0; i < 900 && mon_u.shown.size() < HA * VA; i++)
      @(posedge core_clk);
    #1;
    cmp_cnt(mon_u.shown.size(), HA * VA);
    for (i = 0; i < mon_u.shown.size(); i++)
      cmp_pix(mon_u.shown[i], 12'hA50 + 12'(i));
    cmp_pix({11'h000, refused}, 12'h001);
  endtask
  // Empty buffer for a full frame: black shown, syncs keep running
  task automatic test_underrun;
    int l0;
    int f0;
    int s0;
    int u;
    int cs;
    int rs;
    l0 = line_cnt;
    f0 = frame_cnt;
    s0 = mon_u.shown.size();
    u = 0;
    cs = 0;
    rs = 0;
    repeat (HT * VT)
    begin
      @(posedge core_clk);
      #1;
      if (pix_underrun === 1'b1)
        u++;
      cs += int'(pix_col);
      rs += int'(pix_row);
    end
    cmp_cnt(u, HA * VA);
    cmp_cnt(cs, VA * HA * (HA - 1) / 2);
    cmp_cnt(rs, HA * VA * (VA - 1) / 2);
    cmp_cnt(line_cnt - l0, VT);
    cmp_cnt(frame_cnt - f0, 1);
    cmp_cnt(mon_u.shown.size() - s0, 0);
  endtask
  // Cycle ceiling against hangs
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      miscompares++;
      end_of_test;
    end
  end
  initial
  begin
    repeat (8) @(posedge core_clk);
    #1;
    sys_rst = 1'b0;
    test_reset_idle;
    test_frame_stream;
    test_underrun;
    end_of_test;
  end
endmodule
